// ### src/tmc_pkg.sv
package tmc_pkg;
	localparam int CNT_W = 10;
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_CTRL1 = 8'h04;
	localparam logic [7:0] ADDR_CNT_LO = 8'h08;
	localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
	localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
	localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
	localparam logic [7:0] ADDR_PIN_SEL = 8'h18;
	localparam logic [7:0] ADDR_INT_STAT = 8'h1C;
	localparam logic [7:0] ADDR_INT_MASK = 8'h20;
	// Interrupt bit positions.
	localparam int IRQ_A = 0;
	localparam int IRQ_P = 1;
	// Pin selection bit positions.
	localparam int PIN_CLK = 0;
	localparam int PIN_CAP = 1;
	localparam int PIN_PRI = 2;
	localparam int PIN_INV = 3;
	// Prescaler masks for the divided internal clocks.
	localparam logic [5:0] DIV4_MASK = 6'h03;
	localparam logic [5:0] DIV16_MASK = 6'h0F;
	localparam logic [5:0] DIV64_MASK = 6'h3F;
	localparam logic [9:0] CNT_MAX = 10'h3FF;
	// Clock select codes.
	localparam logic [2:0] CK_SYS4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_H16 = 3'h2;
	localparam logic [2:0] CK_H64 = 3'h3;
	localparam logic [2:0] CK_TBC0 = 3'h4;
	localparam logic [2:0] CK_TBC1 = 3'h5;
	localparam logic [2:0] CK_PINR = 3'h6;
	localparam logic [2:0] CK_PINF = 3'h7;
	// Operating modes.
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_CAP = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;
	// Control register layouts.
	typedef struct packed {
		logic pause;
		logic [2:0] clk_sel;
		logic on;
		logic [2:0] period;
	} tmc_ctrl0_t;
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] io;
		logic oc;
		logic pol;
		logic dpx;
		logic cclr;
	} tmc_ctrl1_t;
	localparam tmc_ctrl0_t CTRL0_RST = 8'h00;
	localparam tmc_ctrl1_t CTRL1_RST = 8'h00;
endpackage

// ### src/tmc_timer.sv
`timescale 1ns/1ps
module tmc_timer (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock sources from the chip.
	input wire logic time_base_tick,
	// Timer pins.
	input wire logic external_clock_pin,
	input wire logic capture_input_pin,
	output logic primary_output_pin,
	output logic primary_output_oe,
	output logic inverted_output_pin,
	output logic inverted_output_oe,
	// Interrupt.
	output logic irq
);
	import tmc_pkg::*;

	tmc_ctrl0_t ctrl0_q;
	tmc_ctrl1_t ctrl1_q;
	logic [9:0] cnt_q;
	logic [9:0] cmpa_q;
	logic [7:0] hold_q;
	logic [3:0] pin_sel_q;
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic [5:0] pre_q;
	logic ck1_q, ck2_q, ck3_q;
	logic cp1_q, cp2_q, cp3_q;
	logic out_q;
	logic [31:0] rd_d;
	logic mapped;
	logic setup, done, wr, rd;
	logic on_rise;
	logic tick;
	logic [9:0] cnt_next;
	logic a_hit, p_hit;
	logic cap_edge;
	logic pwm_active;

	// Period match: a zero field means the full 1024-count overflow.
	function automatic logic period_match(input logic [2:0] per, input logic [9:0] cur);
		period_match = (per == 3'h0) ? (cur == CNT_MAX) : (cur[9:7] == per && cur[6:0] == 7'h7F);
	endfunction

	// Bus phase decode.
	assign setup = psel && !penable;
	assign done = psel && penable && pready;
	assign wr = done && pwrite;
	assign rd = done && !pwrite;
	assign on_rise = wr && paddr == ADDR_CTRL0 && pwdata[3] && !ctrl0_q.on;

	// Address map and read mux.
	always_comb begin
		mapped = 1'b1;
		rd_d = 32'h0000_0000;
		case (paddr)
			ADDR_CTRL0: rd_d[7:0] = ctrl0_q;
			ADDR_CTRL1: rd_d[7:0] = ctrl1_q;
			ADDR_CNT_LO: rd_d[7:0] = hold_q;
			ADDR_CNT_HI: rd_d[1:0] = cnt_q[9:8];
			ADDR_CMPA_LO: rd_d[7:0] = hold_q;
			ADDR_CMPA_HI: rd_d[1:0] = cmpa_q[9:8];
			ADDR_PIN_SEL: rd_d[3:0] = pin_sel_q;
			ADDR_INT_STAT: rd_d[1:0] = stat_q;
			ADDR_INT_MASK: rd_d[1:0] = mask_q;
			default: mapped = 1'b0;
		endcase
	end

	// Answer is prepared in the setup cycle, so the access phase has no wait states.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			prdata <= setup && !pwrite ? rd_d : 32'h0000_0000;
			pslverr <= setup && !mapped;
		end
	end

	// Control and pin selection registers.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrl0_q <= CTRL0_RST;
			ctrl1_q <= CTRL1_RST;
			pin_sel_q <= 4'h0;
			mask_q <= 2'h0;
		end else if (wr) begin
			if (paddr == ADDR_CTRL0) ctrl0_q <= pwdata[7:0];
			if (paddr == ADDR_CTRL1) ctrl1_q <= pwdata[7:0];
			if (paddr == ADDR_PIN_SEL) pin_sel_q <= pwdata[3:0];
			if (paddr == ADDR_INT_MASK) mask_q <= pwdata[1:0];
		end
	end

	// Holding buffer shared by all low bytes.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			hold_q <= 8'h00;
		end else if (wr && paddr == ADDR_CMPA_LO) begin
			hold_q <= pwdata[7:0];
		end else if (rd && paddr == ADDR_CNT_HI) begin
			hold_q <= cnt_q[7:0];
		end else if (rd && paddr == ADDR_CMPA_HI) begin
			hold_q <= cmpa_q[7:0];
		end
	end

	// Pin synchronisers and edge history; edges are found by comparing the second and third stages.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ck1_q <= 1'b0;
			ck2_q <= 1'b0;
			ck3_q <= 1'b0;
			cp1_q <= 1'b0;
			cp2_q <= 1'b0;
			cp3_q <= 1'b0;
		end else begin
			ck1_q <= external_clock_pin;
			ck2_q <= ck1_q;
			ck3_q <= ck2_q;
			cp1_q <= capture_input_pin;
			cp2_q <= cp1_q;
			cp3_q <= cp2_q;
		end
	end

	// Free running prescaler for the divided internal clocks.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) pre_q <= 6'h00;
		else pre_q <= pre_q + 6'h01;
	end

	// Clock source selection; the pin is ignored unless chosen and given to the timer.
	always_comb begin
		case (ctrl0_q.clk_sel)
			CK_SYS4: tick = (pre_q & DIV4_MASK) == DIV4_MASK;
			CK_SYS: tick = 1'b1;
			CK_H16: tick = (pre_q & DIV16_MASK) == DIV16_MASK;
			CK_H64: tick = pre_q == DIV64_MASK;
			CK_TBC0, CK_TBC1: tick = time_base_tick;
			CK_PINR: tick = pin_sel_q[PIN_CLK] && ck2_q && !ck3_q;
			CK_PINF: tick = pin_sel_q[PIN_CLK] && !ck2_q && ck3_q;
			default: tick = 1'b0;
		endcase
	end

	// Comparators look at the value the counter holds when the edge arrives.
	assign cnt_next = cnt_q + 10'h001;
	assign a_hit = ctrl0_q.on && !ctrl0_q.pause && tick && cnt_q == cmpa_q;
	assign p_hit = ctrl0_q.on && !ctrl0_q.pause && tick
		&& period_match(ctrl0_q.period, cnt_q);

	// Counter; a selected match clears it in place of the increment.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_q <= 10'h000;
		end else if (on_rise) begin
			cnt_q <= 10'h000;
		end else if ((a_hit && ctrl1_q.cclr) || (p_hit && !ctrl1_q.cclr)) begin
			cnt_q <= 10'h000;
		end else if (ctrl0_q.on && !ctrl0_q.pause && tick) begin
			cnt_q <= cnt_next;
		end
	end

	// Capture edge selection.
	always_comb begin
		case (ctrl1_q.io)
			2'h0: cap_edge = cp2_q && !cp3_q;
			2'h1: cap_edge = !cp2_q && cp3_q;
			2'h2: cap_edge = cp2_q ^ cp3_q;
			default: cap_edge = 1'b0;
		endcase
	end

	// Compare A value: capture has priority over a software write.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cmpa_q <= 10'h000;
		end else if (ctrl0_q.on && ctrl1_q.mode == MODE_CAP && pin_sel_q[PIN_CAP] && cap_edge) begin
			cmpa_q <= cnt_q;
		end else if (wr && paddr == ADDR_CMPA_HI) begin
			cmpa_q <= {pwdata[1:0], hold_q};
		end
	end

	// Sticky status: hardware set wins over a write-one clear.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stat_q <= 2'h0;
		end else begin
			if (wr && paddr == ADDR_INT_STAT) stat_q <= stat_q & ~pwdata[1:0];
			if (a_hit || (ctrl0_q.on && ctrl1_q.mode == MODE_CAP && pin_sel_q[PIN_CAP]
				&& cap_edge)) stat_q[IRQ_A] <= 1'b1;
			if (p_hit) stat_q[IRQ_P] <= 1'b1;
		end
	end

	// Interrupt output is high while an unmasked status bit is set.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) irq <= 1'b0;
		else irq <= |(stat_q & mask_q);
	end

	// Output state before polarity.
	assign pwm_active = ctrl1_q.dpx ? (cnt_q >= cmpa_q) : (cnt_q < cmpa_q);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			out_q <= 1'b0;
		end else if (on_rise) begin
			out_q <= ctrl1_q.oc;
		end else if (ctrl1_q.mode == MODE_CMP && a_hit) begin
			case (ctrl1_q.io)
				2'h1: out_q <= 1'b0;
				2'h2: out_q <= 1'b1;
				2'h3: out_q <= !out_q;
				default: out_q <= out_q;
			endcase
		end else if (ctrl1_q.mode == MODE_PWM && ctrl0_q.on) begin
			case (ctrl1_q.io)
				2'h0: out_q <= !ctrl1_q.oc;
				2'h1: out_q <= ctrl1_q.oc;
				2'h2: out_q <= pwm_active ? ctrl1_q.oc : !ctrl1_q.oc;
				default: out_q <= !ctrl1_q.oc;
			endcase
		end
	end

	// Pin drivers and enables.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			primary_output_pin <= 1'b0;
			inverted_output_pin <= 1'b1;
			primary_output_oe <= 1'b0;
			inverted_output_oe <= 1'b0;
		end else begin
			primary_output_pin <= out_q ^ ctrl1_q.pol;
			inverted_output_pin <= !(out_q ^ ctrl1_q.pol);
			primary_output_oe <= pin_sel_q[PIN_PRI];
			inverted_output_oe <= pin_sel_q[PIN_INV];
		end
	end

	a_low_write_buf: assert property (@(posedge mclk) disable iff (reset)
		(wr && paddr == ADDR_CMPA_LO) |=> (hold_q == $past(pwdata[7:0]) && $stable(cmpa_q)))
		else $error("low byte write did not stay in buffer");
	a_high_write_cpy: assert property (@(posedge mclk) disable iff (reset)
		(wr && paddr == ADDR_CMPA_HI && !(ctrl1_q.mode == MODE_CAP))
		|=> cmpa_q == {$past(pwdata[1:0]), $past(hold_q)})
		else $error("high byte write did not copy buffer");
	a_high_read_cpy: assert property (@(posedge mclk) disable iff (reset)
		(rd && paddr == ADDR_CNT_HI) |=> hold_q == $past(cnt_q[7:0]))
		else $error("counter high read did not latch low byte");
	a_low_read_buf: assert property (@(posedge mclk) disable iff (reset)
		(setup && !pwrite && paddr == ADDR_CMPA_LO) |=> prdata[7:0] == $past(hold_q))
		else $error("low byte read did not return buffer");
	a_on_clears: assert property (@(posedge mclk) disable iff (reset)
		on_rise |=> cnt_q == 10'h000)
		else $error("counter not cleared on enable");
	a_count_step: assert property (@(posedge mclk) disable iff (reset)
		(ctrl0_q.on && !ctrl0_q.pause && tick && !on_rise && !a_hit && !p_hit)
		|=> cnt_q == $past(cnt_next))
		else $error("counter did not step");
	a_hold_still: assert property (@(posedge mclk) disable iff (reset)
		(!tick && !on_rise) |=> $stable(cnt_q))
		else $error("counter moved without a tick");
	a_match_flag: assert property (@(posedge mclk) disable iff (reset)
		p_hit |=> stat_q[IRQ_P] ##1 (irq || !mask_q[IRQ_P]))
		else $error("period match not flagged");
	a_pin_gate: assert property (@(posedge mclk) disable iff (reset)
		(ctrl0_q.clk_sel[2:1] == 2'h3 && !pin_sel_q[PIN_CLK]) |-> !tick)
		else $error("pin clock leaked while not selected");
	a_cmp_toggle: assert property (@(posedge mclk) disable iff (reset)
		(ctrl1_q.mode == MODE_CMP && ctrl1_q.io == 2'h3 && a_hit && !on_rise)
		|=> out_q != $past(out_q) ##1 primary_output_pin == (out_q ^ ctrl1_q.pol))
		else $error("toggle on match failed");
	c_a_match: cover property (@(posedge mclk) disable iff (reset) a_hit);
	c_p_wrap: cover property (@(posedge mclk) disable iff (reset) p_hit && !ctrl1_q.cclr);
	c_capture: cover property (@(posedge mclk) disable iff (reset)
		ctrl1_q.mode == MODE_CAP && cap_edge && pin_sel_q[PIN_CAP]);
	c_irq: cover property (@(posedge mclk) disable iff (reset) $rose(irq));
endmodule

// ### testbench/tmc_pin_src.sv
`timescale 1ns/1ps
module tmc_pin_src (
	// Clock.
	input wire logic mclk,
	// Pins driven into the timer.
	output logic clk_pin,
	output logic cap_pin
);
	// Both pins idle low until a test moves them.
	initial begin
		clk_pin = 1'b0;
		cap_pin = 1'b0;
	end
	// Pulses are wide enough for the two-flop synchroniser to see each edge.
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge mclk);
			clk_pin <= 1'b1;
			repeat (4) @(posedge mclk);
			clk_pin <= 1'b0;
			repeat (6) @(posedge mclk);
		end
	endtask
	// One level change on the capture pin, then time to settle.
	task automatic cap(input logic v);
		@(posedge mclk);
		cap_pin <= v;
		repeat (8) @(posedge mclk);
	endtask
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import tmc_pkg::*;
	logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, last_dat;
	logic pready, pslverr, last_err, clk_pin, cap_pin, pri, pri_oe, inv, inv_oe, irq;
	logic tbc = 1'b0;
	int failures = 0, cmp_count = 0;
	// Source tables: select code, pin selection, expected count.
	logic [2:0] ck_tab [4] = '{CK_PINR, CK_PINF, CK_TBC0, CK_PINR};
	logic [7:0] ps_tab [4] = '{8'h01, 8'h01, 8'h01, 8'h00};
	logic [7:0] cn_tab [4] = '{8'h05, 8'h05, 8'h05, 8'h00};
	// Compare actions and capture edges: bit1 after rise, bit0 after fall.
	logic [1:0] io_tab [3] = '{2'h3, 2'h1, 2'h2};
	logic oc_tab [3] = '{1'b0, 1'b1, 1'b0};
	logic [1:0] ce_tab [3] = '{2'b10, 2'b01, 2'b11};

	tmc_timer u_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .time_base_tick(tbc), .external_clock_pin(clk_pin),
		.capture_input_pin(cap_pin), .primary_output_pin(pri), .primary_output_oe(pri_oe),
		.inverted_output_pin(inv), .inverted_output_oe(inv_oe), .irq(irq));
	tmc_pin_src u_src (.mclk(mclk), .clk_pin(clk_pin), .cap_pin(cap_pin));

	// Free running 40 MHz clock.
	always #12.5 mclk = ~mclk;

	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Counts a compare and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request holds until pready is seen.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			failures++;
			close_out();
		end
		last_dat = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		chk(last_dat, {24'h00_0000, exp});
	endtask
	// Control word that turns the counter on with a source and period.
	function automatic logic [7:0] on0(input logic [2:0] s, input logic [2:0] p);
		return {1'b0, s, 1'b1, p};
	endfunction

	// Main sequence of tests.
	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		rd(ADDR_CTRL0, 8'h00);
		rd(8'h40, 8'h00);
		chk({31'h0, last_err}, 32'h0000_0001);
		$display("test reset done");
		wr(ADDR_CMPA_LO, 8'h34);
		wr(ADDR_CMPA_HI, 8'h02);
		rd(ADDR_CMPA_HI, 8'h02);
		wr(ADDR_CMPA_LO, 8'h55);
		rd(ADDR_CMPA_LO, 8'h55);
		rd(ADDR_CMPA_HI, 8'h02);
		rd(ADDR_CMPA_LO, 8'h34);
		$display("test buffer done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_PIN_SEL, ps_tab[i]);
			wr(ADDR_CTRL0, 8'h00);
			wr(ADDR_CTRL0, on0(ck_tab[i], 3'h0));
			// Five one-cycle time-base ticks; only the time-base source may count them.
			repeat (5) begin
				@(posedge mclk);
				tbc <= 1'b1;
				@(posedge mclk);
				tbc <= 1'b0;
			end
			u_src.pulse(5);
			rd(ADDR_CNT_HI, 8'h00);
			rd(ADDR_CNT_LO, cn_tab[i]);
		end
		$display("test clock source done");
		wr(ADDR_CMPA_LO, 8'h03);
		wr(ADDR_CMPA_HI, 8'h00);
		wr(ADDR_PIN_SEL, 8'h0D);
		wr(ADDR_INT_MASK, 8'h03);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CTRL0, 8'h00);
			wr(ADDR_INT_STAT, 8'h03);
			wr(ADDR_CTRL1, {MODE_CMP, io_tab[i], oc_tab[i], 3'h1});
			wr(ADDR_CTRL0, on0(CK_PINR, 3'h0));
			u_src.pulse(5);
			chk({31'h0, pri}, {31'h0, !oc_tab[i]});
			chk({30'h0, inv, inv_oe}, {30'h0, oc_tab[i], 1'b1});
			rd(ADDR_INT_STAT, 8'h01);
			chk({31'h0, irq}, 32'h0000_0001);
		end
		wr(ADDR_INT_MASK, 8'h00);
		// The interrupt output is registered one edge behind the mask.
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0000_0000);
		$display("test compare done");
		wr(ADDR_CTRL0, 8'h00);
		wr(ADDR_CMPA_LO, 8'h00);
		wr(ADDR_CMPA_HI, 8'h02);
		wr(ADDR_CTRL1, 8'h00);
		wr(ADDR_INT_STAT, 8'h03);
		wr(ADDR_CTRL0, on0(CK_SYS, 3'h1));
		repeat (300) @(posedge mclk);
		rd(ADDR_CNT_HI, 8'h00);
		rd(ADDR_INT_STAT, 8'h02);
		$display("test period done");
		wr(ADDR_PIN_SEL, 8'h02);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CTRL0, 8'h00);
			wr(ADDR_CTRL1, {MODE_CAP, 2'(i), 4'h0});
			wr(ADDR_CTRL0, on0(CK_PINR, 3'h0));
			wr(ADDR_INT_STAT, 8'h03);
			u_src.cap(1'b1);
			rd(ADDR_INT_STAT, {7'h00, ce_tab[i][1]});
			wr(ADDR_INT_STAT, 8'h03);
			u_src.cap(1'b0);
			rd(ADDR_INT_STAT, {7'h00, ce_tab[i][0]});
		end
		$display("test capture done");
		wr(ADDR_CTRL0, 8'h00);
		wr(ADDR_CMPA_LO, 8'h03);
		wr(ADDR_CMPA_HI, 8'h00);
		wr(ADDR_PIN_SEL, 8'h05);
		wr(ADDR_CTRL1, {MODE_PWM, 2'h2, 1'b1, 3'h0});
		wr(ADDR_CTRL0, on0(CK_PINR, 3'h0));
		repeat (4) @(posedge mclk);
		chk({31'h0, pri}, 32'h0000_0001);
		u_src.pulse(5);
		chk({31'h0, pri}, 32'h0000_0000);
		$display("test pwm done");
		close_out();
	end
endmodule
